/* File: hdl/asm_i2c_slave.sv */
// two-wire serial slave with register pointer and auto increment
`timescale 1ns/1ps
module asm_i2c_slave
    import asm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = asm_pkg::DEV_ADDR_DEFAULT
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe,
    asm_reg_if.port rif
);
    import asm_pkg::*;
    // ************************************************************
    // pin synchronisers and line events
    // ************************************************************
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            {scl_m, scl_s, scl_p} <= 3'h7;
            {sda_m, sda_s, sda_p} <= 3'h7;
        end
        else
        begin
            {scl_p, scl_s, scl_m} <= {scl_s, scl_m, scl_in};
            {sda_p, sda_s, sda_m} <= {sda_s, sda_m, sda_in};
        end
    end
    wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_ev = scl_s & scl_p & ~sda_p & sda_s;
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    // ************************************************************
    // byte engine
    // ************************************************************
    asm_i2c_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] rx_r, tx_r, ptr_r;
    logic rnw_r, first_r, nack_r, wr_r;
    wire byte_done = scl_fall && (cnt_r == BITS_PER_BYTE);
    assign rif.addr = ptr_r;
    assign rif.wdata = rx_r;
    assign rif.wr = wr_r;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            rnw_r <= 1'b0;
            first_r <= 1'b0;
            nack_r <= 1'b0;
            wr_r <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            wr_r <= 1'b0;
            if (start_ev)
            begin
                state_r <= ST_ADDR;
                cnt_r <= 4'h0;
                first_r <= 1'b1;
                sda_oe <= 1'b0;
            end
            else if (stop_ev)
            begin
                state_r <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_ADDR, ST_WRITE:
                    begin
                        if (scl_rise)
                        begin
                            rx_r <= {rx_r[6:0], sda_s};
                            cnt_r <= cnt_r + 4'h1;
                        end
                        else if (byte_done && state_r == ST_ADDR)
                        begin
                            if (rx_r[7:1] == DEV_ADDR)
                            begin
                                rnw_r <= rx_r[0];
                                sda_oe <= 1'b1;
                                state_r <= ST_ACK_ADDR;
                            end
                            else
                                state_r <= ST_IDLE;
                        end
                        else if (byte_done)
                        begin
                            sda_oe <= 1'b1;
                            state_r <= ST_ACK_WR;
                            if (first_r)
                                ptr_r <= rx_r;
                            else
                                wr_r <= 1'b1;
                        end
                    end
                    ST_ACK_ADDR:
                    begin
                        if (scl_fall)
                        begin
                            cnt_r <= 4'h0;
                            tx_r <= rif.rdata;
                            sda_oe <= rnw_r & ~rif.rdata[7];
                            state_r <= rnw_r ? ST_READ : ST_WRITE;
                        end
                    end
                    ST_ACK_WR:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                            cnt_r <= 4'h0;
                            first_r <= 1'b0;
                            if (!first_r)
                                ptr_r <= ptr_r + 8'h01;
                            state_r <= ST_WRITE;
                        end
                    end
                    ST_READ:
                    begin
                        if (scl_rise)
                            cnt_r <= cnt_r + 4'h1;
                        else if (byte_done)
                        begin
                            sda_oe <= 1'b0;
                            state_r <= ST_ACK_RD;
                        end
                        else if (scl_fall)
                        begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe <= ~tx_r[6];
                        end
                    end
                    ST_ACK_RD:
                    begin
                        if (scl_rise)
                        begin
                            nack_r <= sda_s;
                            if (!sda_s)
                                ptr_r <= ptr_r + 8'h01;
                        end
                        else if (scl_fall && nack_r)
                            state_r <= ST_IDLE;
                        else if (scl_fall)
                        begin
                            cnt_r <= 4'h0;
                            tx_r <= rif.rdata;
                            sda_oe <= ~rif.rdata[7];
                            state_r <= ST_READ;
                        end
                    end
                    default:
                        state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: hdl/asm_pkg.sv */
// constants and types shared by the status register bank and its serial port
package asm_pkg;
    // ************************************************************
    // register offsets and pages
    // ************************************************************
    localparam logic [7:0] OFS_PAGE = 8'h00;
    localparam logic [7:0] OFS_FOLLOW = 8'h06;
    localparam logic [7:0] OFS_MUTE_MON = 8'h6C;
    localparam logic [7:0] OFS_BOOT_PWR = 8'h76;
    localparam logic [7:0] OFS_PIN_STATE = 8'h77;
    localparam logic [7:0] OFS_AUTO_MUTE = 8'h78;
    localparam logic [7:0] OFS_MODE_SEL = 8'h79;
    localparam logic [7:0] PAGE_0 = 8'h00;
    localparam logic [7:0] PAGE_1 = 8'h01;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int B_DUMMY_L = 5;
    localparam int B_DUMMY_R = 4;
    localparam int B_MAIN_L = 1;
    localparam int B_MAIN_R = 0;
    localparam int B_BOOT = 7;
    localparam int B_PIN = 5;
    localparam int B_AUTO_L = 4;
    localparam int B_AUTO_R = 0;
    localparam int B_MODE = 0;
    localparam int B_FOLLOW = 0;
    localparam int PSTATE_W = 4;
    localparam int CHAN_W = 4;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic RST_MODE = 1'b0;
    localparam logic RST_FOLLOW = 1'b1;
    localparam logic [7:0] RST_PAGE = 8'h00;
    // ************************************************************
    // power state codes
    // ************************************************************
    localparam logic [3:0] PS_POWERDOWN = 4'h0;
    localparam logic [3:0] PS_RUN = 4'h5;
    localparam logic [3:0] PS_STANDBY = 4'h8;
    // ************************************************************
    // serial port
    // ************************************************************
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // arbitrary value
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_WRITE,
        ST_ACK_WR,
        ST_READ,
        ST_ACK_RD
    } asm_i2c_state_t;
endpackage

/* File: hdl/asm_reg_if.sv */
// register access carrier between serial port and register bank
`timescale 1ns/1ps
interface asm_reg_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdata;
    modport port (output addr, output wdata, output wr, input rdata);
    modport bank (input addr, input wdata, input wr, output rdata);
endinterface

/* File: hdl/asm_status_regs.sv */
// amplifier status and control register bank behind the serial control port
//
// Contract
// - bit5 of 0x6C: left dummy unmuted
// - bit4 of 0x6C: right dummy unmuted
// - bit1 of 0x6C: left analog unmuted
// - bit0 of 0x6C: right analog unmuted
// - bit7 of 0x76: signal processor boot done
// - bits3:0 of 0x76: converter power state code
// - bit5 of 0x77: sampled general input level
// - bit4 of 0x78: left auto mute flag
// - bit0 of 0x78: right auto mute flag
// - bit0 of 0x79: mode select, resets 0
// - follow control 0 makes analog track digital
`timescale 1ns/1ps
module asm_status_regs
    import asm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = asm_pkg::DEV_ADDR_DEFAULT
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [1:0] DIGITAL_MUTE,
    input wire logic [asm_pkg::CHAN_W-1:0] ANALOG_UNMUTE_REQ,
    input wire logic DSP_BOOT_DONE,
    input wire logic [asm_pkg::PSTATE_W-1:0] POWER_STATE_CODE,
    input wire logic GENERAL_INPUT_LEVEL,
    input wire logic [1:0] AUTO_MUTE,
    output logic [asm_pkg::CHAN_W-1:0] ANALOG_UNMUTE,
    output logic CONVERTER_MODE
);
    import asm_pkg::*;
    // ************************************************************
    // serial port
    // ************************************************************
    asm_reg_if rif();
    asm_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port
    (
        .clk(CLK),
        .reset(RESET),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .sda_oe(SDA_OE),
        .rif(rif.port)
    );
    // ************************************************************
    // state flops
    // ************************************************************
    logic [7:0] page_r;
    logic follow_r, boot_r, pin_m, pin_s;
    logic [PSTATE_W-1:0] pstate_r;
    logic [1:0] auto_r;
    logic [CHAN_W-1:0] unmute_nxt;
    // channel order: dummy left, dummy right, left, right
    wire [CHAN_W-1:0] dmute4 = {DIGITAL_MUTE, DIGITAL_MUTE};
    assign unmute_nxt = follow_r ? ANALOG_UNMUTE_REQ : ~dmute4;
    // ************************************************************
    // write decode
    // ************************************************************
    wire in_page0 = (page_r == PAGE_0);
    wire in_page1 = (page_r == PAGE_1);
    wire page_wr = rif.wr && (rif.addr == OFS_PAGE);
    wire mode_wr = rif.wr && in_page0 && (rif.addr == OFS_MODE_SEL);
    wire follow_wr = rif.wr && in_page1 && (rif.addr == OFS_FOLLOW);
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            page_r <= RST_PAGE;
            CONVERTER_MODE <= RST_MODE;
            follow_r <= RST_FOLLOW;
            SDA_OUT <= 1'b0;
        end
        else
        begin
            if (page_wr)
                page_r <= rif.wdata;
            if (mode_wr)
                CONVERTER_MODE <= rif.wdata[B_MODE];
            if (follow_wr)
                follow_r <= rif.wdata[B_FOLLOW];
        end
    end
    // live status capture; no write path reaches these
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ANALOG_UNMUTE <= '0;
            boot_r <= 1'b0;
            pstate_r <= '0;
            auto_r <= 2'h0;
            pin_m <= 1'b0;
            pin_s <= 1'b0;
        end
        else
        begin
            ANALOG_UNMUTE <= unmute_nxt;
            boot_r <= DSP_BOOT_DONE;
            pstate_r <= POWER_STATE_CODE;
            auto_r <= AUTO_MUTE;
            pin_m <= GENERAL_INPUT_LEVEL;
            pin_s <= pin_m;
        end
    end
    // ************************************************************
    // read words and select
    // ************************************************************
    wire [7:0] mon_word = ({7'h00, ANALOG_UNMUTE[3]} << B_DUMMY_L)
        | ({7'h00, ANALOG_UNMUTE[2]} << B_DUMMY_R)
        | ({7'h00, ANALOG_UNMUTE[1]} << B_MAIN_L)
        | ({7'h00, ANALOG_UNMUTE[0]} << B_MAIN_R);
    wire [7:0] boot_word = ({7'h00, boot_r} << B_BOOT) | {4'h0, pstate_r};
    wire [7:0] pin_word = {7'h00, pin_s} << B_PIN;
    wire [7:0] auto_word = ({7'h00, auto_r[1]} << B_AUTO_L)
        | ({7'h00, auto_r[0]} << B_AUTO_R);
    wire [7:0] mode_word = {7'h00, CONVERTER_MODE} << B_MODE;
    wire [7:0] follow_word = {7'h00, follow_r} << B_FOLLOW;
    wire hit_mon = in_page0 && (rif.addr == OFS_MUTE_MON);
    wire hit_boot = in_page0 && (rif.addr == OFS_BOOT_PWR);
    wire hit_pin = in_page0 && (rif.addr == OFS_PIN_STATE);
    wire hit_auto = in_page0 && (rif.addr == OFS_AUTO_MUTE);
    wire hit_mode = in_page0 && (rif.addr == OFS_MODE_SEL);
    wire hit_follow = in_page1 && (rif.addr == OFS_FOLLOW);
    assign rif.rdata = (rif.addr == OFS_PAGE) ? page_r :
        hit_mon ? mon_word :
        hit_boot ? boot_word :
        hit_pin ? pin_word :
        hit_auto ? auto_word :
        hit_mode ? mode_word :
        hit_follow ? follow_word : 8'h00;
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    a_dummy_mon: assert property (hit_mon |-> rif.rdata[5:4] == ($past(follow_r) ?
        $past(ANALOG_UNMUTE_REQ[3:2]) : ~$past(DIGITAL_MUTE)))
        else $error("dummy mute monitor bits wrong");
    a_main_mon: assert property (hit_mon |-> rif.rdata[1:0] == ($past(follow_r) ?
        $past(ANALOG_UNMUTE_REQ[1:0]) : ~$past(DIGITAL_MUTE)))
        else $error("analog mute monitor bits wrong");
    a_boot_power_live: assert property (hit_boot |->
        rif.rdata == {$past(DSP_BOOT_DONE), 3'h0, $past(POWER_STATE_CODE)})
        else $error("boot or power state readback wrong");
    a_pin_sync: assert property (hit_pin |->
        rif.rdata == ({7'h00, $past(GENERAL_INPUT_LEVEL, 2)} << B_PIN))
        else $error("input pin readback wrong");
    a_auto_flags: assert property (hit_auto |-> rif.rdata[4] == $past(AUTO_MUTE[1])
        && rif.rdata[0] == $past(AUTO_MUTE[0]) && rif.rdata[3:1] == 3'h0)
        else $error("auto mute flags wrong");
    a_mode_write: assert property (mode_wr |=> CONVERTER_MODE == $past(rif.wdata[B_MODE]))
        else $error("mode write not taken");
    a_mode_hold: assert property (!mode_wr |=> $stable(CONVERTER_MODE))
        else $error("mode changed without write");
    a_follow_on: assert property (!follow_r |=> ANALOG_UNMUTE == ~$past(dmute4))
        else $error("analog mute not following digital");
    a_follow_off: assert property (follow_r |=> ANALOG_UNMUTE == $past(ANALOG_UNMUTE_REQ))
        else $error("analog mute not from request");
    a_ro_write: assert property (rif.wr && (hit_mon || hit_boot || hit_pin || hit_auto)
        |=> $stable(CONVERTER_MODE) && $stable(follow_r) && $stable(page_r))
        else $error("status write disturbed control");
endmodule

/* File: dv/asm_status_regs_tb.sv */
// self-checking bench for the amplifier status register bank
`timescale 1ns/1ps
module asm_status_regs_tb;
    import asm_pkg::*;
    // ****************************************
    // signals and design
    // ****************************************
    logic clk = 1'b0;
    logic reset, scl, sda_m, sda_in, sda_out, sda_oe, boot, pin, mode, mode_exp;
    logic [1:0] dmute, amute;
    logic [3:0] req, pstate, unmute;
    logic [7:0] got_b;
    logic [7:0] exp_q[$];
    logic [31:0] rng;
    int n_errors = 0;
    int checked = 0;
    event got_ev;
    // open-drain line with pull-up; the device drives its data level while enabled
    assign sda_in = sda_m & (~sda_oe | sda_out);
    asm_status_regs dut (.CLK(clk), .RESET(reset), .SCL_IN(scl), .SDA_IN(sda_in),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .DIGITAL_MUTE(dmute), .ANALOG_UNMUTE_REQ(req),
        .DSP_BOOT_DONE(boot), .POWER_STATE_CODE(pstate), .GENERAL_INPUT_LEVEL(pin),
        .AUTO_MUTE(amute), .ANALOG_UNMUTE(unmute), .CONVERTER_MODE(mode));
    // ****************************************
    // helpers and serial master
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic cmpo(input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        tick(4);
        scl = 1'b1;
        tick(6);
        r = sda_in;
        tick(6);
        scl = 1'b0;
        tick(4);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(ack, a);
    endtask
    task automatic start();
        sda_m = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(6);
        sda_m = 1'b0;
        tick(6);
        scl = 1'b0;
        tick(4);
    endtask
    task automatic stop();
        sda_m = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(6);
        sda_m = 1'b1;
        tick(6);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        start();
        byte_io({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r);
        byte_io(a, 1'b1, r);
        byte_io(d, 1'b1, r);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] r;
        start();
        byte_io({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r);
        byte_io(a, 1'b1, r);
        start();
        byte_io({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, r);
        for (int i = 0; i < n; i++)
        begin
            byte_io(8'hFF, (i == n - 1), r);
            got_b = r;
            ->got_ev;
        end
        stop();
    endtask
    // watcher: oldest note against each byte read back
    always @(got_ev)
        cmp8(exp_q.pop_front(), got_b);
    task automatic check_status(input logic [3:0] u);
        exp_q.push_back({2'h0, u[3], u[2], 2'h0, u[1], u[0]});
        rd(OFS_MUTE_MON, 1);
        exp_q.push_back({boot, 3'h0, pstate});
        exp_q.push_back({2'h0, pin, 5'h00});
        exp_q.push_back({3'h0, amute[1], 3'h0, amute[0]});
        exp_q.push_back({7'h00, mode_exp});
        rd(OFS_BOOT_PWR, 4);
        cmpo(u, unmute);
    endtask
    task automatic shake();
        rng = xs(rng);
        {dmute, req, boot, pin, amute} = rng[9:0];
        pstate = (rng[13:10] > 4'h8) ? rng[13:10] - 4'h8 : rng[13:10];
        tick(4);
    endtask
    task automatic do_reset();
        reset = 1'b1;
        tick(4);
        reset = 1'b0;
        mode_exp = 1'b0;
        tick(4);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ****************************************
    // clock, watchdog and scenarios
    // ****************************************
    initial
    begin
        forever #10 clk = ~clk;
    end
    initial
    begin
        #1_200_000;
        n_errors++;
        complete_run();
    end
    initial
    begin
        rng = 32'h000038F1;
        {reset, scl, sda_m, boot, pin, mode_exp} = 6'h3C;
        {dmute, amute, req, pstate} = 12'h000;
        do_reset();
        shake();
        cmpo(req, unmute);
        for (int k = 0; k < 4; k++)
        begin
            shake();
            check_status(req);
        end
        // writes to status places touch defined bits only and must not stick
        wr(OFS_MUTE_MON, 8'h33);
        wr(OFS_BOOT_PWR, 8'h8F);
        wr(OFS_AUTO_MUTE, 8'h11);
        check_status(req);
        wr(OFS_MODE_SEL, 8'h01);
        mode_exp = 1'b1;
        tick(2);
        cmpo({3'h0, mode_exp}, {3'h0, mode});
        check_status(req);
        for (int c = 0; c < 9; c++)
        begin
            pstate = 4'(c);
            tick(2);
            exp_q.push_back({boot, 3'h0, pstate});
            rd(OFS_BOOT_PWR, 1);
        end
        // enable mute following on the second page
        wr(OFS_PAGE, PAGE_1);
        wr(OFS_FOLLOW, 8'h00);
        exp_q.push_back(8'h00);
        rd(OFS_FOLLOW, 1);
        wr(OFS_PAGE, PAGE_0);
        for (int k = 0; k < 3; k++)
        begin
            shake();
            check_status(~{dmute[1], dmute[0], dmute[1], dmute[0]});
        end
        // second reset restores mode and following defaults
        do_reset();
        cmpo(4'h0, {3'h0, mode});
        check_status(req);
        complete_run();
    end
endmodule
